/* File: logic/pcr_pkg.sv */
// pcr_pkg: shared constants for the synthesizer control register bank and its host
// assumes: 100 MHz system clock, 24-bit registers addressed by a 5-bit index
package pcr_pkg;
	// register indices on the link
	localparam logic [4:0] PCR_IDX_ID     = 5'h00;
	localparam logic [4:0] PCR_IDX_ENABLE = 5'h01;
	localparam logic [4:0] PCR_IDX_REFDIV = 5'h02;
	localparam logic [4:0] PCR_IDX_INT    = 5'h03;
	localparam logic [4:0] PCR_IDX_FRAC   = 5'h04;
	localparam logic [4:0] PCR_IDX_SUBSYS = 5'h05;

	// field positions
	localparam int PCR_RDIDX_MSB    = 4;
	localparam int PCR_SOFTRST_BIT  = 5;
	localparam int PCR_ENSEL_BIT    = 0;
	localparam int PCR_SPIEN_BIT    = 1;
	localparam int PCR_KEEP_LSB     = 2;
	localparam int PCR_SUB_SEL_MSB  = 2;
	localparam int PCR_SUB_IDX_LSB  = 3;
	localparam int PCR_SUB_IDX_MSB  = 6;
	localparam int PCR_SUB_PAY_LSB  = 7;
	localparam int PCR_SUB_PAY_MSB  = 15;

	// values after reset
	localparam logic [9:0]  PCR_ENABLE_RST = 10'h002;
	localparam logic [13:0] PCR_REFDIV_RST = 14'h0001;
	localparam logic [18:0] PCR_INT_RST    = 19'h00019;
	localparam logic [23:0] PCR_FRAC_RST   = 24'h000000;
	localparam logic [15:0] PCR_SUBSYS_RST = 16'h0000;

	// legal ranges the host keeps
	localparam logic [23:0] PCR_REFDIV_MIN   = 24'h000001;
	localparam logic [23:0] PCR_REFDIV_MAX   = 24'h003fff;
	localparam logic [23:0] PCR_INT_FRAC_MIN = 24'h000014;
	localparam logic [23:0] PCR_INT_FRAC_MAX = 24'h07fffc;
	localparam logic [23:0] PCR_INT_INT_MIN  = 24'h000010;
	localparam logic [23:0] PCR_INT_INT_MAX  = 24'h07ffff;

	// internal link timing: half period of the link clock in system cycles
	localparam int PCR_SYS_CLK_MHZ   = 100;
	localparam int PCR_LINK_MAX_MHZ  = 50;
	localparam int PCR_LINK_HALF_CYC =
		(PCR_SYS_CLK_MHZ + 2 * PCR_LINK_MAX_MHZ - 1) / (2 * PCR_LINK_MAX_MHZ);

	// host apb register offsets
	localparam logic [7:0] PCR_APB_CTRL   = 8'h00;
	localparam logic [7:0] PCR_APB_ADDR   = 8'h04;
	localparam logic [7:0] PCR_APB_WDATA  = 8'h08;
	localparam logic [7:0] PCR_APB_RDATA  = 8'h0c;
	localparam logic [7:0] PCR_APB_STATUS = 8'h10;

	// host control bits
	localparam int PCR_CTRL_GO      = 0;
	localparam int PCR_CTRL_WRITE   = 1;
	localparam int PCR_CTRL_FRAC    = 2;
	localparam int PCR_CTRL_SOFTRST = 3;
	localparam int PCR_CTRL_CALGRD  = 4;

	typedef enum logic [0:0] {PCR_FWD_IDLE, PCR_FWD_SHIFT} pcr_fwd_type;
endpackage

/* File: logic/pcr_link_if.sv */
// pcr_link_if: register access link between host controller and register bank
// assumes: both ends on one clock; req held until ack
`timescale 1ns/10ps
interface pcr_link_if;
	logic        req;
	logic        we;
	logic [4:0]  addr;
	logic [23:0] wdata;
	logic        ack;
	logic [23:0] rdata;

	modport dev  (input req, input we, input addr, input wdata, output ack, output rdata);
	modport host (output req, output we, output addr, output wdata, input ack, input rdata);
endinterface

/* File: logic/pcr_device.sv */
// pcr_device: control register bank of the synthesizer with subsystem forwarding
// assumes: host holds req until ack; enable pin is asynchronous
`timescale 1ns/10ps

// Functional notes
// - index zero reads fixed 24-bit identification
// - written index picks next returned register
// - bit 5 of index zero soft-resets
// - host zeroes upper bits writing index zero
// - select bit picks pin or register enable
// - register enable bit resets to one
// - keep bits hold blocks powered when disabled
// - reference divider 14 bits, reset 1
// - integer divider 19 bits, reset 25
// - fractional value applied only in fractional mode
// - subsystem port fields select, index, payload
// - subsystem port writes forward packets, newest pending one wins
// - subsystem port reads last forwarded value
// - packets shifted out msb first
// - link clock at most 50 MHz
// - calibration overwrites only payload field
// - host uses subsystem select zero
module pcr_device
	import pcr_pkg::*;
#(
	parameter logic [23:0] ID_VALUE = 24'h3c5a96, // arbitrary value
	parameter int          PKT_BITS = 16
) (
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	pcr_link_if.dev          lnk,
	input  wire logic        enable_input_pin_i,
	input  wire logic        frac_mode_i,
	input  wire logic        cal_valid_i,
	input  wire logic [8:0]  cal_payload_i,
	output logic             synth_enable_o,
	output logic [5:0]       block_power_o,
	output logic [13:0]      reference_divide_o,
	output logic [18:0]      integer_divide_o,
	output logic [23:0]      fractional_divide_o,
	output logic             link_clk_o,
	output logic             link_data_o,
	output logic             link_frame_o
);
	logic [4:0]           read_index_r;
	logic [9:0]           enable_r;
	logic [13:0]          refdiv_r;
	logic [18:0]          intdiv_r;
	logic [23:0]          frac_r;
	logic [15:0]          subsys_r;
	logic [15:0]          pend_r;
	logic                 pend_valid_r;
	logic                 ack_r;
	logic [23:0]          rdata_r;
	logic [2:0]           pin_sync_r;
	logic                 pin_level_r;
	logic                 synth_en_r;
	logic [5:0]           power_r;
	logic [23:0]          frac_out_r;
	pcr_fwd_type          fwd_state_r;
	logic [PKT_BITS-1:0]  shift_r;
	logic [4:0]           bit_cnt_r;
	logic                 link_clk_r;
	logic                 frame_r;
	logic [7:0]           tick_cnt_r;
	logic                 tick;
	logic                 take;
	logic                 wr;
	logic                 soft_rst;
	logic                 en_now;
	logic [15:0]          sub_next;

	// readback mux shared by the answer path
	function automatic logic [23:0] read_reg(input logic [4:0] idx);
		logic [23:0] v;
		v = 24'h000000;
		unique case (idx)
			PCR_IDX_ID:     v = ID_VALUE;
			PCR_IDX_ENABLE: v = {14'h0000, enable_r};
			PCR_IDX_REFDIV: v = {10'h000, refdiv_r};
			PCR_IDX_INT:    v = {5'h00, intdiv_r};
			PCR_IDX_FRAC:   v = frac_r;
			PCR_IDX_SUBSYS: v = {8'h00, subsys_r};
			default:        v = 24'h000000;
		endcase
		return v;
	endfunction

	// request decode
	assign take     = lnk.req && !ack_r;
	assign wr       = take && lnk.we;
	assign soft_rst = wr && (lnk.addr == PCR_IDX_ID) && lnk.wdata[PCR_SOFTRST_BIT];

	// link answer: one cycle after a request, data from the previously written index
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ack_r   <= 1'b0;
			rdata_r <= 24'h000000;
		end else begin
			ack_r <= take;
			if (take) begin
				rdata_r <= read_reg(read_index_r);
			end
		end
	end
	assign lnk.ack   = ack_r;
	assign lnk.rdata = rdata_r;

	// index zero write: read index and soft reset strobe only
	always_ff @(posedge clk_i) begin
		if (srst_i || soft_rst) begin
			read_index_r <= 5'h00;
		end else if (wr && lnk.addr == PCR_IDX_ID) begin
			read_index_r <= lnk.wdata[PCR_RDIDX_MSB:0];
		end
	end

	// plain read/write divider and enable registers
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			enable_r <= PCR_ENABLE_RST;
			refdiv_r <= PCR_REFDIV_RST;
			intdiv_r <= PCR_INT_RST;
			frac_r   <= PCR_FRAC_RST;
		end else if (wr) begin
			unique case (lnk.addr)
				PCR_IDX_ENABLE: enable_r <= lnk.wdata[9:0];
				PCR_IDX_REFDIV: refdiv_r <= lnk.wdata[13:0];
				PCR_IDX_INT:    intdiv_r <= lnk.wdata[18:0];
				PCR_IDX_FRAC:   frac_r   <= lnk.wdata;
				default: ;
			endcase
		end
	end

	// enable pin: three stages, change accepted when the last two agree
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pin_sync_r  <= 3'h0;
			pin_level_r <= 1'b0;
		end else begin
			pin_sync_r <= {pin_sync_r[1:0], enable_input_pin_i};
			if (pin_sync_r[1] == pin_sync_r[2]) begin
				pin_level_r <= pin_sync_r[2];
			end
		end
	end

	assign en_now = enable_r[PCR_ENSEL_BIT] ? pin_level_r : enable_r[PCR_SPIEN_BIT];

	// enable, block power and divide values driven to the synthesizer
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			synth_en_r <= 1'b0;
			power_r    <= 6'h00;
			frac_out_r <= 24'h000000;
		end else begin
			synth_en_r <= en_now;
			power_r    <= {6{en_now}} | enable_r[PCR_KEEP_LSB +: 6];
			frac_out_r <= frac_mode_i ? frac_r : 24'h000000;
		end
	end
	assign synth_enable_o      = synth_en_r;
	assign block_power_o       = power_r;
	assign reference_divide_o  = refdiv_r;
	assign integer_divide_o    = intdiv_r;
	assign fractional_divide_o = frac_out_r;

	// next packet: host write value, calibration replaces only the payload
	always_comb begin
		sub_next = pend_valid_r ? pend_r : subsys_r;
		if (wr && lnk.addr == PCR_IDX_SUBSYS) begin
			sub_next = lnk.wdata[15:0];
		end
		if (cal_valid_i) begin
			sub_next[PCR_SUB_PAY_MSB:PCR_SUB_PAY_LSB] = cal_payload_i;
		end
	end

	// pending packet: newest request wins, forwarded once the link is free
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pend_r       <= PCR_SUBSYS_RST;
			pend_valid_r <= 1'b0;
		end else if ((wr && lnk.addr == PCR_IDX_SUBSYS) || cal_valid_i) begin
			pend_r       <= sub_next;
			pend_valid_r <= 1'b1;
		end else if (fwd_state_r == PCR_FWD_IDLE) begin
			pend_valid_r <= 1'b0;
		end
	end

	// link rate divider, one-cycle tick per half period
	always_ff @(posedge clk_i) begin
		if (srst_i || fwd_state_r == PCR_FWD_IDLE) begin
			tick_cnt_r <= 8'h00;
		end else if (tick) begin
			tick_cnt_r <= 8'h00;
		end else begin
			tick_cnt_r <= tick_cnt_r + 8'h01;
		end
	end
	assign tick = (tick_cnt_r == 8'(PCR_LINK_HALF_CYC - 1));

	// forwarding machine: data changes on falling link clock, msb first
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			fwd_state_r <= PCR_FWD_IDLE;
			subsys_r    <= PCR_SUBSYS_RST;
			shift_r     <= '0;
			bit_cnt_r   <= 5'h00;
			link_clk_r  <= 1'b0;
			frame_r     <= 1'b0;
		end else begin
			unique case (fwd_state_r)
				PCR_FWD_IDLE: begin
					if (pend_valid_r) begin
						subsys_r    <= pend_r;
						shift_r     <= pend_r;
						bit_cnt_r   <= 5'(PKT_BITS);
						frame_r     <= 1'b1;
						link_clk_r  <= 1'b0;
						fwd_state_r <= PCR_FWD_SHIFT;
					end
				end
				PCR_FWD_SHIFT: begin
					if (tick) begin
						link_clk_r <= !link_clk_r;
						if (link_clk_r) begin
							shift_r   <= {shift_r[PKT_BITS-2:0], 1'b0};
							bit_cnt_r <= bit_cnt_r - 5'h01;
							if (bit_cnt_r == 5'h01) begin
								frame_r     <= 1'b0;
								fwd_state_r <= PCR_FWD_IDLE;
							end
						end
					end
				end
			endcase
		end
	end
	assign link_clk_o   = link_clk_r;
	assign link_data_o  = shift_r[PKT_BITS-1];
	assign link_frame_o = frame_r;
endmodule // pcr_device

/* File: logic/pcr_host.sv */
// pcr_host: apb-programmed controller that drives the register bank link
// assumes: apb master on the same clock; device answers each request with ack
`timescale 1ns/10ps
module pcr_host
	import pcr_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic             pready_o,
	output logic             pslverr_o,
	output logic [31:0]      prdata_o,
	pcr_link_if.host         lnk
);
	logic [4:0]  ctrl_r;
	logic [4:0]  addr_r;
	logic [23:0] wdata_r;
	logic [23:0] rdata_r;
	logic        busy_r;
	logic        refused_r;
	logic        pready_r;
	logic        pslverr_r;
	logic [31:0] prdata_r;
	logic        req_r;
	logic        we_r;
	logic [4:0]  laddr_r;
	logic [23:0] lwdata_r;
	logic        setup;
	logic        access;
	logic        go;
	logic        legal;
	logic [23:0] out_data;

	// reads are prepared at setup; writes land only at the edge where pready is seen high
	assign setup  = psel_i && !penable_i && !pready_r;
	assign access = psel_i && penable_i && pready_r;
	assign go     = access && pwrite_i && paddr_i == PCR_APB_CTRL && pwdata_i[PCR_CTRL_GO];

	// outgoing data shaped and checked per target register
	always_comb begin
		out_data = wdata_r;
		legal    = 1'b1;
		if (pwdata_i[PCR_CTRL_WRITE]) begin
			unique case (addr_r)
				PCR_IDX_ID: begin
					out_data = {18'h00000, pwdata_i[PCR_CTRL_SOFTRST], wdata_r[4:0]};
				end
				PCR_IDX_REFDIV: begin
					legal = wdata_r >= PCR_REFDIV_MIN && wdata_r <= PCR_REFDIV_MAX;
				end
				PCR_IDX_INT: begin
					legal = pwdata_i[PCR_CTRL_FRAC] ?
						(wdata_r >= PCR_INT_FRAC_MIN && wdata_r <= PCR_INT_FRAC_MAX) :
						(wdata_r >= PCR_INT_INT_MIN && wdata_r <= PCR_INT_INT_MAX);
				end
				PCR_IDX_SUBSYS: begin
					out_data[PCR_SUB_SEL_MSB:0] = 3'h0;
					if (pwdata_i[PCR_CTRL_CALGRD]) begin
						out_data[PCR_SUB_IDX_MSB:PCR_SUB_IDX_LSB] = 4'h0;
					end
				end
				default: ;
			endcase
		end
	end

	// apb slave: ready in the first access cycle
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h00000000;
		end else begin
			pready_r  <= setup;
			pslverr_r <= 1'b0;
			if (setup) begin
				pslverr_r <= paddr_i > PCR_APB_STATUS || paddr_i[1:0] != 2'h0;
				unique case (paddr_i)
					PCR_APB_CTRL:   prdata_r <= {27'h0000000, ctrl_r};
					PCR_APB_ADDR:   prdata_r <= {27'h0000000, addr_r};
					PCR_APB_WDATA:  prdata_r <= {8'h00, wdata_r};
					PCR_APB_RDATA:  prdata_r <= {8'h00, rdata_r};
					PCR_APB_STATUS: prdata_r <= {30'h00000000, refused_r, busy_r};
					default:        prdata_r <= 32'h00000000;
				endcase
			end
		end
	end
	assign pready_o  = pready_r;
	assign pslverr_o = pslverr_r;
	assign prdata_o  = prdata_r;

	// software registers
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ctrl_r  <= 5'h00;
			addr_r  <= 5'h00;
			wdata_r <= 24'h000000;
		end else if (access && pwrite_i) begin
			unique case (paddr_i)
				PCR_APB_CTRL:  ctrl_r  <= {pwdata_i[4:1], 1'b0};
				PCR_APB_ADDR:  addr_r  <= pwdata_i[4:0];
				PCR_APB_WDATA: wdata_r <= pwdata_i[23:0];
				default: ;
			endcase
		end
	end

	// link master: request held until the device acknowledges
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			req_r     <= 1'b0;
			we_r      <= 1'b0;
			laddr_r   <= 5'h00;
			lwdata_r  <= 24'h000000;
			busy_r    <= 1'b0;
			refused_r <= 1'b0;
			rdata_r   <= 24'h000000;
		end else if (busy_r) begin
			if (lnk.ack) begin
				req_r   <= 1'b0;
				busy_r  <= 1'b0;
				rdata_r <= lnk.rdata;
			end
		end else if (go) begin
			refused_r <= !legal;
			if (legal) begin
				req_r    <= 1'b1;
				busy_r   <= 1'b1;
				we_r     <= pwdata_i[PCR_CTRL_WRITE];
				laddr_r  <= addr_r;
				lwdata_r <= out_data;
			end
		end
	end
	assign lnk.req   = req_r;
	assign lnk.we    = we_r;
	assign lnk.addr  = laddr_r;
	assign lnk.wdata = lwdata_r;
endmodule // pcr_host

/* File: test/pcr_chk.sv */
// pcr_chk: assertions on the link between host controller and register bank
// assumes: one clock, instantiated beside the link interface
`timescale 1ns/10ps
module pcr_chk
	import pcr_pkg::*;
#(
	parameter logic [23:0] ID_VALUE = 24'h3c5a96 // arbitrary value
) (
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	input  wire logic        req,
	input  wire logic        we,
	input  wire logic [4:0]  addr,
	input  wire logic [23:0] wdata,
	input  wire logic        ack,
	input  wire logic [23:0] rdata,
	input  wire logic        cal_valid,
	input  wire logic [8:0]  cal_payload
);
	logic        take_w;
	logic [4:0]  idx_r;
	logic [23:0] sh_r [1:5];
	logic [23:0] exp_rd;
	// a write is taken on an edge with req high and no ack yet
	assign take_w = req && !ack && we;
	// read index model, the soft reset bit clears it
	always_ff @(posedge clk_i) begin
		if (srst_i)
			idx_r <= 5'h00;
		else if (take_w && addr == PCR_IDX_ID)
			idx_r <= wdata[PCR_SOFTRST_BIT] ? 5'h00 : wdata[4:0];
	end
	// shadow of the writable registers
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			sh_r[1] <= 24'h000002;
			sh_r[2] <= 24'h000001;
			sh_r[3] <= 24'h000019;
			sh_r[4] <= 24'h000000;
			sh_r[5] <= 24'h000000;
		end else begin
			if (take_w && addr >= PCR_IDX_ENABLE && addr <= PCR_IDX_SUBSYS)
				sh_r[addr] <= wdata;
			// a calibration pulse replaces only the payload of the subsystem port
			if (cal_valid)
				sh_r[5][15:7] <= cal_payload;
		end
	end
	// value a read must return for the current read index
	always_comb begin
		case (idx_r)
			PCR_IDX_ID:     exp_rd = ID_VALUE;
			PCR_IDX_ENABLE: exp_rd = {14'h0000, sh_r[1][9:0]};
			PCR_IDX_REFDIV: exp_rd = {10'h000, sh_r[2][13:0]};
			PCR_IDX_INT:    exp_rd = {5'h00, sh_r[3][18:0]};
			PCR_IDX_FRAC:   exp_rd = sh_r[4];
			PCR_IDX_SUBSYS: exp_rd = {8'h00, sh_r[5][15:0]};
			default:        exp_rd = 24'h000000;
		endcase
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	property p_ack_next; req && !ack |=> ack; endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack late");
	property p_ack_pulse; ack |=> !ack; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_req_hold; req && !ack |=> $stable(we) && $stable(addr) && $stable(wdata); endproperty
	a_req_hold: assert property (p_req_hold) else $error("request moved");
	property p_req_drop; ack |=> !req; endproperty
	a_req_drop: assert property (p_req_drop) else $error("req kept");
	property p_rd; req && !ack && !we |=> rdata == $past(exp_rd); endproperty
	a_rd: assert property (p_rd) else $error("read data wrong");
	property p_rd_id; req && !ack && !we && idx_r == 5'h00 |=> rdata == ID_VALUE; endproperty
	a_rd_id: assert property (p_rd_id) else $error("id wrong");
	property p_idx0; take_w && addr == PCR_IDX_ID |-> wdata[23:6] == 18'h00000; endproperty
	a_idx0: assert property (p_idx0) else $error("upper bits set");
	property p_sel; take_w && addr == PCR_IDX_SUBSYS |-> wdata[2:0] == 3'h0; endproperty
	a_sel: assert property (p_sel) else $error("select not zero");
	property p_ref;
		take_w && addr == PCR_IDX_REFDIV |-> wdata >= 24'h000001 && wdata <= 24'h003fff;
	endproperty
	a_ref: assert property (p_ref) else $error("divider out of range");
	property p_int;
		take_w && addr == PCR_IDX_INT |-> wdata >= 24'h000010 && wdata <= 24'h07ffff;
	endproperty
	a_int: assert property (p_int) else $error("integer out of range");
endmodule // pcr_chk

/* File: test/pll_control_register_bank_tb_top.sv */
// pll_control_register_bank_tb_top: host controller and register bank joined by the link
// assumes: apb driven here, calibration input pulsed once for one cycle
`timescale 1ns/10ps
module pll_control_register_bank_tb_top
	import pcr_pkg::*;
;
	localparam logic [23:0] TB_ID = 24'h5e21c7; // arbitrary value
	localparam logic [31:0] GO    = 32'h1 << PCR_CTRL_GO;
	localparam logic [31:0] WR    = 32'h1 << PCR_CTRL_WRITE;
	localparam logic [31:0] FR    = 32'h1 << PCR_CTRL_FRAC;
	localparam logic [31:0] SR    = 32'h1 << PCR_CTRL_SOFTRST;
	localparam logic [31:0] CG    = 32'h1 << PCR_CTRL_CALGRD;
	logic        clk_i, srst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
	logic [7:0]  paddr_i;
	logic [31:0] pwdata_i, prdata_o, st, q, q2;
	logic        pin, fm, se, lc, ld, lf, lc_q, lf_q;
	logic [5:0]  bp;
	logic        cv;
	logic [8:0]  cp;
	logic [13:0] rdv;
	logic [18:0] idv;
	logic [23:0] fdv;
	logic [23:0] rst_v [8];
	logic [15:0] pk, exp_pkt;
	int          n_mismatch, checked, nb, n_frm, cyc, i;
	pcr_link_if lnk ();
	pcr_device #(.ID_VALUE(TB_ID)) pcr_device_i (
		.clk_i(clk_i), .srst_i(srst_i), .lnk(lnk), .enable_input_pin_i(pin), .frac_mode_i(fm),
		.cal_valid_i(cv), .cal_payload_i(cp), .synth_enable_o(se), .block_power_o(bp),
		.reference_divide_o(rdv), .integer_divide_o(idv), .fractional_divide_o(fdv),
		.link_clk_o(lc), .link_data_o(ld), .link_frame_o(lf));
	pcr_host pcr_host_i (
		.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .prdata_o(prdata_o), .lnk(lnk));
	pcr_chk #(.ID_VALUE(TB_ID)) pcr_chk_i (
		.clk_i(clk_i), .srst_i(srst_i), .req(lnk.req), .we(lnk.we), .addr(lnk.addr),
		.wdata(lnk.wdata), .ack(lnk.ack), .rdata(lnk.rdata), .cal_valid(cv),
		.cal_payload(cp));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic results;
		$display("mismatches %0d, checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// one apb transfer, held until pready is seen
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r);
		@(posedge clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		r = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	// one link operation through the controller, waits until not busy
	task automatic op(input logic [31:0] c, input logic [4:0] a, input logic [23:0] d,
			output logic [31:0] s, output logic [31:0] r);
		apb(1'b1, PCR_APB_WDATA, {8'h00, d}, r);
		apb(1'b1, PCR_APB_ADDR, {27'h0, a}, r);
		apb(1'b1, PCR_APB_CTRL, c | GO, r);
		// a busy flag that never clears ends through the cycle ceiling
		do begin
			apb(1'b0, PCR_APB_STATUS, 32'h0, s);
		end while (s[0] !== 1'b0);
		apb(1'b0, PCR_APB_RDATA, 32'h0, r);
	endtask
	task automatic rd(input logic [4:0] a, output logic [31:0] r);
		op(WR, PCR_IDX_ID, {19'h0, a}, st, r);
		op(32'h0, PCR_IDX_ID, 24'h0, st, r);
	endtask
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// cycle ceiling: a hang counts as a mismatch and goes to the report
	always @(posedge clk_i) begin
		cyc++;
		if (cyc > 20000) begin
			n_mismatch++;
			$display("MISMATCH at %0t: timeout", $time);
			results;
		end
	end
	// watch the forwarding link: collect bits on rising link clock
	always @(posedge clk_i) begin
		if (lc === 1'b1 && lc_q === 1'b0) begin
			pk = {pk[14:0], ld};
			nb++;
		end
		if (lf_q === 1'b1 && lf === 1'b0) begin
			chk(pk, exp_pkt);
			chk(nb, 16);
			nb = 0;
			n_frm++;
		end
		lc_q = lc;
		lf_q = lf;
	end
	initial begin
		{psel_i, penable_i, pwrite_i, pin, fm, cv, nb, n_frm, cyc} = '0;
		{paddr_i, pwdata_i, cp} = '0;
		srst_i = 1'b1;
		rst_v = '{TB_ID, 24'h2, 24'h1, 24'h19, 24'h0, 24'h0, 24'h0, 24'h0};
		repeat (10) @(posedge clk_i);
		srst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk(se, 1'b1);
		chk(bp, 6'h3f);
		chk(rdv, 14'h1);
		chk(idv, 19'h19);
		chk(fdv, 24'h0);
		for (i = 0; i < 8; i++) begin
			rd(i[4:0], q);
			chk(q, rst_v[i]);
		end
		// disabled with some keep bits, then enable taken from the pin
		op(WR, PCR_IDX_ENABLE, 24'h000014, st, q);
		chk({se, bp}, {1'b0, 6'h05});
		op(WR, PCR_IDX_ENABLE, 24'h000001, st, q);
		pin <= 1'b1;
		repeat (6) @(posedge clk_i);
		chk({se, bp}, {1'b1, 6'h3f});
		pin <= 1'b0;
		repeat (6) @(posedge clk_i);
		chk({se, bp}, {1'b0, 6'h00});
		// divider limits, out of range values are refused
		op(WR, PCR_IDX_REFDIV, 24'h003fff, st, q);
		chk(rdv, 14'h3fff);
		op(WR, PCR_IDX_REFDIV, 24'h000000, st, q);
		chk({st[1], rdv}, {1'b1, 14'h3fff});
		op(WR, PCR_IDX_INT, 24'h07ffff, st, q);
		chk(idv, 19'h7ffff);
		op(WR | FR, PCR_IDX_INT, 24'h07fffd, st, q);
		chk({st[1], idv}, {1'b1, 19'h7ffff});
		op(WR | FR, PCR_IDX_INT, 24'h000014, st, q);
		chk({st[1], idv}, {1'b0, 19'h00014});
		// fractional value only applies in fractional mode
		op(WR, PCR_IDX_FRAC, 24'habcdef, st, q);
		chk(fdv, 24'h0);
		fm <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk(fdv, 24'habcdef);
		// two forwarded packets, select forced to zero
		exp_pkt = {9'h1a5, 4'h3, 3'h0};
		op(WR, PCR_IDX_SUBSYS, {8'h00, 9'h1a5, 4'h3, 3'h5}, st, q);
		repeat (40) @(posedge clk_i);
		rd(PCR_IDX_SUBSYS, q);
		chk(q, {8'h00, exp_pkt});
		exp_pkt = {9'h0f0, 4'h0, 3'h0};
		op(WR, PCR_IDX_SUBSYS, {8'h00, exp_pkt}, st, q);
		repeat (40) @(posedge clk_i);
		chk(n_frm, 2);
		// calibration guard clears the index, then a calibration pulse swaps only the payload
		exp_pkt = {9'h055, 4'h0, 3'h0};
		op(WR | CG, PCR_IDX_SUBSYS, {8'h00, 9'h055, 4'h6, 3'h2}, st, q);
		repeat (40) @(posedge clk_i);
		exp_pkt = {9'h1c3, 4'h0, 3'h0};
		cv <= 1'b1;
		cp <= 9'h1c3;
		@(posedge clk_i);
		cv <= 1'b0;
		repeat (40) @(posedge clk_i);
		rd(PCR_IDX_SUBSYS, q);
		chk(q, {8'h00, exp_pkt});
		chk(n_frm, 4);
		// read index persists, soft reset clears it
		op(WR, PCR_IDX_ID, 24'h000003, st, q);
		op(32'h0, PCR_IDX_ID, 24'h0, st, q);
		op(32'h0, PCR_IDX_ID, 24'h0, st, q2);
		chk(q, 32'h14);
		chk(q2, 32'h14);
		op(WR | SR, PCR_IDX_ID, 24'h000003, st, q);
		op(32'h0, PCR_IDX_ID, 24'h0, st, q);
		chk(q, {8'h00, TB_ID});
		// unmapped apb address answers with an error
		apb(1'b0, 8'h14, 32'h0, q);
		chk(err, 1'b1);
		results;
	end
endmodule // pll_control_register_bank_tb_top
